// [verilog/uip_consts.vh]
// Constants for the channel interrupt prioritizer.
`ifndef UIP_CONSTS_VH
`define UIP_CONSTS_VH
// Register addresses on the three address lines.
`define UIP_ADDR_DATA 3'h0
`define UIP_ADDR_MASK 3'h1
`define UIP_ADDR_SRC 3'h2
`define UIP_ADDR_EFR 3'h2
`define UIP_ADDR_LCTL 3'h3
`define UIP_ADDR_LSTAT 3'h5
`define UIP_ADDR_MSTAT 3'h6
`define UIP_ADDR_RES1 3'h4
`define UIP_ADDR_RES2 3'h5
`define UIP_ADDR_PAUSE1 3'h6
`define UIP_ADDR_PAUSE2 3'h7
// Line control value that opens the enhanced window.
`define UIP_LCR_ENH 8'hbf
`define UIP_LCR_DLAB 7
// Field positions.
`define UIP_EFR_ENH_BIT 4
`define UIP_FCR_EN_BIT 0
// Reset values.
`define UIP_MASK_RST 8'h00
`define UIP_EFR_RST 8'h00
`define UIP_CHAR_RST 8'h00
`define UIP_LCR_RST 8'h00
// Interrupt source codes, bits 5 to 0.
`define UIP_CODE_LINE 6'h06
`define UIP_CODE_TMO 6'h0c
`define UIP_CODE_RX_READY_SOURCE 6'h04
`define UIP_CODE_TX_READY_SOURCE 6'h02
`define UIP_CODE_MODEM 6'h00
`define UIP_CODE_XOFF 6'h10
`define UIP_CODE_FLOW 6'h20
`define UIP_CODE_NONE 6'h01
// Timeout: four characters plus twelve bits.
`define UIP_TMO_CHARS 4
`define UIP_TMO_BITS 12
`endif

// [verilog/uip_timeout.v]
// Receive timeout counter measured in bit-time ticks.
`timescale 1ns/1ps
`default_nettype none
`include "uip_consts.vh"
module uip_timeout #(
    parameter CW = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire bit_tick_i,
    input wire [3:0] char_bits_i,
    input wire data_waiting_i,
    input wire restart_i,
    input wire clear_i,
    output reg fire_o
);
    reg [CW-1:0] cnt_q;
    wire [CW-1:0] limit;
    wire [CW-1:0] bits_ext;
    localparam [CW-1:0] TMO_BITS = `UIP_TMO_BITS;

    assign bits_ext = {{(CW-4){1'b0}}, char_bits_i};
    assign limit = (bits_ext << 2) + TMO_BITS;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= {CW{1'b0}};
            fire_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i || !data_waiting_i) begin
                cnt_q <= {CW{1'b0}};
            end else if (bit_tick_i && !fire_o) begin
                cnt_q <= cnt_q + 1'b1;
            end
            if (clear_i || !data_waiting_i) begin
                fire_o <= 1'b0;
            end else if (bit_tick_i && cnt_q + 1'b1 >= limit) begin
                fire_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/uip_top.v]
// Channel interrupt mask, prioritizer, status encoder and enhanced window.
`timescale 1ns/1ps
`default_nettype none
`include "uip_consts.vh"
// How it works
// - Enhanced fields locked unless feature bit four set
// - Mask bit zero gates receive-data interrupt
// - FIFO receive interrupt follows trigger level
// - Data-ready set on arrival, cleared when empty
// - Line status bits report errors and empties
// - Transmit-ready on empty, immediate when enabled empty
// - Overrun immediate; other errors at read-out
// - Modem mask; sleep bit enhanced-only; reset zero
// - Mask bit five gates pause-character interrupt
// - Mask bit six gates RTS rising
// - Mask bit seven gates CTS rising
// - Status read shows highest pending source only
// - Timeout after four chars plus twelve bits
// - Transmit-ready cleared by data write or by a status read that shows it
// - Line interrupt cleared by line-status read
// - Modem interrupt from delta bits, read clears
// - Pause cleared by status read or resume
// - Flow interrupts cleared by modem-status read
// - Source codes encode priority order
// - Bit zero high when nothing pending
// - Bits seven and six show FIFO enable
module uip_top #(
    parameter TMO_W = 8
) (
    // Clock, reset, enable.
    input wire CORE_CLK_I,
    input wire RST_I,
    input wire CE_I,
    // Host register bus.
    input wire [2:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    // Channel state from the datapath.
    input wire [7:0] LCR_I,
    input wire FIFO_EN_I,
    input wire RX_HAS_DATA_I,
    input wire RX_AT_TRIGGER_I,
    input wire RX_CHAR_STROBE_I,
    input wire RX_OVERRUN_I,
    input wire [2:0] RX_HEAD_ERR_I,
    input wire RX_FIFO_ERR_I,
    input wire TX_READY_LEVEL_I,
    input wire TX_ALL_EMPTY_I,
    input wire [3:0] MODEM_DELTA_I,
    input wire [3:0] MODEM_LEVEL_I,
    input wire BIT_TICK_I,
    input wire [3:0] CHAR_BITS_I,
    input wire PAUSE_RX_I,
    input wire RESUME_RX_I,
    input wire SPECIAL_RX_I,
    input wire RTS_RISE_I,
    input wire CTS_RISE_I,
    // Control outputs.
    output wire [7:0] ENH_FEATURE_O,
    output wire SLEEP_EN_O,
    output wire [31:0] FLOW_CHARS_O,
    output wire INT_O
);
    // ------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------
    reg [7:0] interrupt_mask_q;
    reg [7:0] enhanced_feature_q;
    reg [7:0] flow_resume_char_first_q;
    reg [7:0] flow_resume_char_second_q;
    reg [7:0] flow_pause_char_first_q;
    reg [7:0] flow_pause_char_second_q;
    reg line_pend_q;
    reg overrun_q;
    reg modem_pend_q;
    reg [3:0] modem_delta_q;
    reg tx_pend_q;
    reg tx_level_q;
    reg pause_pend_q;
    reg special_pend_q;
    reg flow_pend_q;
    reg rx_strobe_seen_q;
    wire enh_win;
    wire enh_on;
    wire dlab;
    wire rd_data;
    wire rd_src;
    wire rd_lstat;
    wire rd_mstat;
    wire wr_data;
    wire wr_mask;
    wire tmo_fire;
    reg [5:0] src_code;
    reg [7:0] line_status;

    function sel;
        input [2:0] a;
        input [2:0] want;
        begin
            sel = (a == want);
        end
    endfunction

    assign enh_win = (LCR_I == `UIP_LCR_ENH);
    assign enh_on = enhanced_feature_q[`UIP_EFR_ENH_BIT];
    assign dlab = LCR_I[`UIP_LCR_DLAB];
    assign rd_data = CE_I && RD_I && !dlab && sel(ADDR_I, `UIP_ADDR_DATA);
    assign rd_src = CE_I && RD_I && !enh_win && sel(ADDR_I, `UIP_ADDR_SRC);
    assign rd_lstat = CE_I && RD_I && !enh_win && sel(ADDR_I, `UIP_ADDR_LSTAT);
    assign rd_mstat = CE_I && RD_I && !enh_win && sel(ADDR_I, `UIP_ADDR_MSTAT);
    assign wr_data = CE_I && WR_I && !dlab && sel(ADDR_I, `UIP_ADDR_DATA);
    assign wr_mask = CE_I && WR_I && !dlab && sel(ADDR_I, `UIP_ADDR_MASK);

    // ------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            interrupt_mask_q <= `UIP_MASK_RST;
            enhanced_feature_q <= `UIP_EFR_RST;
            flow_resume_char_first_q <= `UIP_CHAR_RST;
            flow_resume_char_second_q <= `UIP_CHAR_RST;
            flow_pause_char_first_q <= `UIP_CHAR_RST;
            flow_pause_char_second_q <= `UIP_CHAR_RST;
        end else if (CE_I && WR_I) begin
            if (wr_mask) begin
                interrupt_mask_q[3:0] <= WDATA_I[3:0];
                if (enh_on) begin
                    interrupt_mask_q[7:4] <= WDATA_I[7:4];
                end
            end
            if (enh_win) begin
                if (sel(ADDR_I, `UIP_ADDR_EFR)) begin
                    enhanced_feature_q <= WDATA_I;
                end
                if (sel(ADDR_I, `UIP_ADDR_RES1)) begin
                    flow_resume_char_first_q <= WDATA_I;
                end
                if (sel(ADDR_I, `UIP_ADDR_RES2)) begin
                    flow_resume_char_second_q <= WDATA_I;
                end
                if (sel(ADDR_I, `UIP_ADDR_PAUSE1)) begin
                    flow_pause_char_first_q <= WDATA_I;
                end
                if (sel(ADDR_I, `UIP_ADDR_PAUSE2)) begin
                    flow_pause_char_second_q <= WDATA_I;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pending sources; a set in the clearing cycle wins, except for the timeout, where the clear wins.
    // ------------------------------------------------------------
    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            line_pend_q <= 1'b0;
            overrun_q <= 1'b0;
            modem_pend_q <= 1'b0;
            modem_delta_q <= 4'h0;
            tx_pend_q <= 1'b0;
            tx_level_q <= 1'b0;
            pause_pend_q <= 1'b0;
            special_pend_q <= 1'b0;
            flow_pend_q <= 1'b0;
            rx_strobe_seen_q <= 1'b0;
        end else if (CE_I) begin
            tx_level_q <= TX_READY_LEVEL_I;
            rx_strobe_seen_q <= RX_CHAR_STROBE_I;
            if (RX_OVERRUN_I) begin
                overrun_q <= 1'b1;
            end else if (rd_lstat) begin
                overrun_q <= 1'b0;
            end
            // Overrun flags at once; head errors flag as they reach the read side.
            if (RX_OVERRUN_I || (rd_data && |RX_HEAD_ERR_I)) begin
                line_pend_q <= 1'b1;
            end else if (rd_lstat) begin
                line_pend_q <= 1'b0;
            end
            if (|MODEM_DELTA_I) begin
                modem_pend_q <= 1'b1;
                modem_delta_q <= modem_delta_q | MODEM_DELTA_I;
            end else if (rd_mstat) begin
                modem_pend_q <= 1'b0;
                modem_delta_q <= 4'h0;
            end
            // Rising readiness, or enabling while already ready, raises transmit-ready.
            if ((TX_READY_LEVEL_I && !tx_level_q) ||
                (wr_mask && WDATA_I[1] && !interrupt_mask_q[1] && TX_READY_LEVEL_I)) begin
                tx_pend_q <= 1'b1;
            end else if (wr_data || (rd_src && src_code == `UIP_CODE_TX_READY_SOURCE)) begin
                tx_pend_q <= 1'b0;
            end
            if (PAUSE_RX_I && enh_on) begin
                pause_pend_q <= 1'b1;
            end else if (rd_src || RESUME_RX_I) begin
                pause_pend_q <= 1'b0;
            end
            if (SPECIAL_RX_I && enh_on) begin
                special_pend_q <= 1'b1;
            end else if (rd_src || (RX_CHAR_STROBE_I && !rx_strobe_seen_q)) begin
                special_pend_q <= 1'b0;
            end
            if ((RTS_RISE_I && interrupt_mask_q[6]) ||
                (CTS_RISE_I && interrupt_mask_q[7])) begin
                flow_pend_q <= enh_on;
            end else if (rd_mstat) begin
                flow_pend_q <= 1'b0;
            end
        end
    end

    uip_timeout #(
        .CW(TMO_W)
    ) u_tmo (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .bit_tick_i(BIT_TICK_I),
        .char_bits_i(CHAR_BITS_I),
        .data_waiting_i(RX_HAS_DATA_I),
        .restart_i(RX_CHAR_STROBE_I | rd_data),
        .clear_i(rd_data),
        .fire_o(tmo_fire)
    );

    // ------------------------------------------------------------
    // Priority encoder.
    // ------------------------------------------------------------
    wire rx_ready_source;
    wire tx_ready_source;
    wire [6:0] act;

    // Without FIFOs the trigger is one character.
    assign rx_ready_source = FIFO_EN_I ? RX_AT_TRIGGER_I : RX_HAS_DATA_I;
    assign tx_ready_source = tx_pend_q;
    assign act[0] = interrupt_mask_q[2] && line_pend_q;
    assign act[1] = interrupt_mask_q[0] && tmo_fire;
    assign act[2] = interrupt_mask_q[0] && rx_ready_source;
    assign act[3] = interrupt_mask_q[1] && tx_ready_source;
    assign act[4] = interrupt_mask_q[3] && modem_pend_q;
    assign act[5] = enh_on && interrupt_mask_q[5] && (pause_pend_q | special_pend_q);
    assign act[6] = enh_on && flow_pend_q;

    always @* begin
        if (act[0]) begin
            src_code = `UIP_CODE_LINE;
        end else if (act[1]) begin
            src_code = `UIP_CODE_TMO;
        end else if (act[2]) begin
            src_code = `UIP_CODE_RX_READY_SOURCE;
        end else if (act[3]) begin
            src_code = `UIP_CODE_TX_READY_SOURCE;
        end else if (act[4]) begin
            src_code = `UIP_CODE_MODEM;
        end else if (act[5]) begin
            src_code = `UIP_CODE_XOFF;
        end else if (act[6]) begin
            src_code = `UIP_CODE_FLOW;
        end else begin
            src_code = `UIP_CODE_NONE;
        end
    end

    always @* begin
        line_status[0] = RX_HAS_DATA_I;
        line_status[1] = overrun_q;
        line_status[4:2] = RX_HEAD_ERR_I;
        line_status[5] = TX_READY_LEVEL_I;
        line_status[6] = TX_ALL_EMPTY_I;
        line_status[7] = RX_FIFO_ERR_I;
    end

    // ------------------------------------------------------------
    // Read data, registered.
    // ------------------------------------------------------------
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (enh_win) begin
            case (ADDR_I)
                `UIP_ADDR_EFR: rd_d = enhanced_feature_q;
                `UIP_ADDR_RES1: rd_d = flow_resume_char_first_q;
                `UIP_ADDR_RES2: rd_d = flow_resume_char_second_q;
                `UIP_ADDR_PAUSE1: rd_d = flow_pause_char_first_q;
                `UIP_ADDR_PAUSE2: rd_d = flow_pause_char_second_q;
                default: rd_d = 8'h00;
            endcase
        end else begin
            case (ADDR_I)
                `UIP_ADDR_MASK: rd_d = dlab ? 8'h00 : interrupt_mask_q;
                `UIP_ADDR_SRC: rd_d = {{2{FIFO_EN_I}}, src_code};
                `UIP_ADDR_LSTAT: rd_d = line_status;
                `UIP_ADDR_MSTAT: rd_d = {MODEM_LEVEL_I, modem_delta_q};
                default: rd_d = 8'h00;
            endcase
        end
    end

    always @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h00;
        end else if (CE_I && RD_I) begin
            RDATA_O <= rd_d;
        end
    end

    assign ENH_FEATURE_O = enhanced_feature_q;
    assign SLEEP_EN_O = enh_on && interrupt_mask_q[4];
    assign FLOW_CHARS_O = {flow_pause_char_second_q, flow_pause_char_first_q,
                           flow_resume_char_second_q, flow_resume_char_first_q};
    assign INT_O = |act;
endmodule
`default_nettype wire

// [verif/uip_chk_assertions.sv]
// Assertion checker for the channel interrupt prioritizer.
`timescale 1ns/1ps
`default_nettype none
module uip_chk (
    // Clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Register bus.
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    // Channel state and outputs.
    input wire logic [7:0] LCR_I,
    input wire logic FIFO_EN_I,
    input wire logic [7:0] ENH_FEATURE_O,
    input wire logic SLEEP_EN_O,
    input wire logic INT_O
);
    default clocking dcb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    sequence s_isr;
        RD_I && ADDR_I == 3'h2 && !LCR_I[7];
    endsequence
    sequence s_efr;
        WR_I && ADDR_I == 3'h2 && LCR_I == 8'hbf;
    endsequence
    AST_ISR_FIFO: assert property (s_isr |=> RDATA_O[7:6] == {2{$past(FIFO_EN_I)}})
        else $error("status fifo bits wrong");
    AST_ISR_IDLE: assert property (s_isr |=> RDATA_O[0] == !$past(INT_O))
        else $error("status idle bit disagrees with interrupt");
    AST_ISR_CODE: assert property (s_isr |=> RDATA_O[5:0] inside {6'h06, 6'h0c, 6'h04,
        6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("status code illegal");
    AST_ISR_UPPER: assert property (s_isr ##0 !ENH_FEATURE_O[4] |=> RDATA_O[5:4] == 2'h0)
        else $error("upper status bits active while locked");
    AST_SLEEP_LOCK: assert property (!ENH_FEATURE_O[4] |-> !SLEEP_EN_O)
        else $error("sleep enabled while locked");
    AST_EFR_WR: assert property (s_efr |=> ENH_FEATURE_O == $past(WDATA_I))
        else $error("feature register write lost");
    AST_RST_QUIET: assert property ($past(RST_I) |-> !INT_O)
        else $error("interrupt right after reset");
    AST_RD_HOLD: assert property (!RD_I |=> $stable(RDATA_O))
        else $error("read data changed without read");
endmodule
`default_nettype wire

// [verif/uip_host.sv]
// Host processor model driving the register bus.
`timescale 1ns/1ps
`default_nettype none
module uip_host (
    // Clock and read data.
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    // Bus requests.
    output logic [2:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 3'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = v;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~v;
    endtask
    // Polls any register; used for line status polling with mask bits cleared.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        v = rdata_i;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the channel interrupt prioritizer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, wr, rd, fifo_en, has_data, at_trig, fifo_err, tx_lvl, tx_empty, tick, int_o;
    logic [2:0] addr, head_err;
    logic [3:0] mlevel, cb;
    logic [7:0] wdata, rdata, line_control_reg, d, v, ev, enh, slp;
    logic [31:0] rv, flow;
    int num_errors, samples_checked, n;
    logic [7:0] evs [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
    logic [5:0] cds [5] = '{6'h06, 6'h00, 6'h10, 6'h20, 6'h20};
    logic [2:0] clr [5] = '{3'h5, 3'h6, 3'h2, 3'h6, 3'h6};
    uip_host host_u (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    uip_top dut_u (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LCR_I(line_control_reg), .FIFO_EN_I(fifo_en),
        .RX_HAS_DATA_I(has_data), .RX_AT_TRIGGER_I(at_trig), .RX_CHAR_STROBE_I(ev[5]),
        .RX_OVERRUN_I(ev[0]), .RX_HEAD_ERR_I(head_err), .RX_FIFO_ERR_I(fifo_err),
        .TX_READY_LEVEL_I(tx_lvl), .TX_ALL_EMPTY_I(tx_empty), .MODEM_DELTA_I({4{ev[1]}}),
        .MODEM_LEVEL_I(mlevel), .BIT_TICK_I(tick), .CHAR_BITS_I(cb), .PAUSE_RX_I(ev[2]),
        .RESUME_RX_I(ev[6]), .SPECIAL_RX_I(ev[7]), .RTS_RISE_I(ev[4]), .CTS_RISE_I(ev[3]),
        .ENH_FEATURE_O(enh), .SLEEP_EN_O(slp[0]), .FLOW_CHARS_O(flow), .INT_O(int_o));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic fire(input logic [7:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 8'h00;
    endtask
    // Checks the interrupt line, then reads the status register.
    task automatic interrupt_source(input logic [5:0] code);
        @(negedge clk);
        check("int", {7'h00, int_o}, {7'h00, code != 6'h01});
        host_u.rd(3'h2, d);
        check("isr", d, {fifo_en, fifo_en, code});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        {rst, fifo_en, has_data, at_trig, fifo_err, tx_lvl, tx_empty, tick} = 8'h80;
        {head_err, mlevel, cb, line_control_reg, ev} = 27'h000_0000;
        rv = $urandom(77293);
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        host_u.rd(3'h1, d);
        check("mask rst", d, 8'h00);
        interrupt_source(6'h01);
        host_u.wr(3'h1, 8'hf0);
        host_u.rd(3'h1, d);
        check("mask lock", d, 8'h00);
        line_control_reg = 8'hbf;
        host_u.wr(3'h2, 8'h10);
        for (int i = 4; i < 8; i++) begin
            v = 8'($urandom);
            host_u.wr(3'(i), v);
            host_u.rd(3'(i), d);
            check("char", d, v);
            check("flow", flow[8*(i-4) +: 8], v);
        end
        host_u.rd(3'h2, d);
        check("efr", d, 8'h10);
        check("enh", enh, 8'h10);
        line_control_reg = 8'h03;
        host_u.wr(3'h1, 8'hff);
        host_u.rd(3'h1, d);
        check("mask enh", d, 8'hff);
        check("sleep", {7'h00, slp[0]}, 8'h01);
        // Each single source, its code, then its own clearing access.
        for (int i = 0; i < 5; i++) begin
            fire(evs[i]);
            interrupt_source(cds[i]);
            if (clr[i] != 3'h2) host_u.rd(clr[i], d);
            interrupt_source(6'h01);
        end
        tx_lvl = 1'b1;
        fire(8'h01);
        interrupt_source(6'h06);
        host_u.rd(3'h5, d);
        interrupt_source(6'h02);
        interrupt_source(6'h01);
        host_u.wr(3'h1, 8'hfd);
        host_u.wr(3'h1, 8'hff);
        interrupt_source(6'h02);
        tx_lvl = 1'b0;
        @(negedge clk) tx_lvl = 1'b1;
        host_u.wr(3'h0, 8'($urandom));
        interrupt_source(6'h01);
        fifo_en = 1'b1;
        at_trig = 1'b1;
        interrupt_source(6'h04);
        at_trig = 1'b0;
        interrupt_source(6'h01);
        fifo_en = 1'b0;
        has_data = 1'b1;
        interrupt_source(6'h04);
        has_data = 1'b0;
        interrupt_source(6'h01);
        fifo_en = 1'b1;
        cb = 4'h7 + 4'($urandom % 6);
        n = 4 * cb + 12;
        has_data = 1'b1;
        tick = 1'b1;
        repeat (n - 4) @(negedge clk);
        tick = 1'b0;
        interrupt_source(6'h01);
        tick = 1'b1;
        repeat (4) @(negedge clk);
        tick = 1'b0;
        interrupt_source(6'h0c);
        host_u.rd(3'h0, d);
        interrupt_source(6'h01);
        host_u.wr(3'h1, 8'h00);
        repeat (20) begin
            rv = $urandom;
            {fifo_en, has_data, fifo_err, tx_empty, head_err, mlevel} = rv[10:0];
            host_u.rd(3'h5, d);
            check("lsr", {2'h0, d[7:6], d[4:2], d[0]}, {2'h0, fifo_err, tx_empty, head_err, has_data});
            interrupt_source(6'h01);
        end
        final_report();
    end
endmodule
bind uip_top uip_chk chk_u (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .LCR_I(LCR_I),
    .FIFO_EN_I(FIFO_EN_I), .ENH_FEATURE_O(ENH_FEATURE_O), .SLEEP_EN_O(SLEEP_EN_O), .INT_O(INT_O));
`default_nettype wire
